//--- logic/ifp_debounce.sv
// two-stage synchroniser and debounce filter per push-button
`timescale 1ns/1ps
module ifp_debounce #(
    parameter int N = 4,
    parameter int CNT_MAX = 2_000_000
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous reset, high
    input wire logic [N-1:0] raw, // button pins, high when pressed
    output logic [N-1:0] stable // debounced levels
);
    localparam int CW = $clog2(CNT_MAX + 1);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] stab;
        logic [N-1:0][CW-1:0] cnt;
    } ifp_deb_st_t;

    ifp_deb_st_t q, d;

    if (N < 1 || CNT_MAX < 1) begin : g_chk
        $error("ifp_debounce: bad parameters");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // a level must hold CNT_MAX cycles before it is taken
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        for (int i = 0; i < N; i++) begin
            if (q.s2[i] == q.stab[i]) begin
                d.cnt[i] = '0;
            end else if (q.cnt[i] == CW'(CNT_MAX - 1)) begin
                d.cnt[i] = '0;
                d.stab[i] = q.s2[i];
            end else begin
                d.cnt[i] = q.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign stable = q.stab;

endmodule : ifp_debounce

//--- logic/ifp_panel_ctrl.sv
// front-panel control: start-up display, button views, menu entry, code check, storing
`timescale 1ns/1ps
module ifp_panel_ctrl #(
    parameter int START_DELAY_CYC = ifp_pkg::START_DELAY_CYC,
    parameter int TEST_CYC = ifp_pkg::TEST_CYC,
    parameter int BLANK_CYC = ifp_pkg::BLANK_CYC,
    parameter int DASH_CYC = ifp_pkg::DASH_CYC,
    parameter int DASH_STEP_CYC = ifp_pkg::DASH_STEP_CYC,
    parameter int STORE_CYC = ifp_pkg::STORE_CYC,
    parameter int DEBOUNCE_CYC = ifp_pkg::DEBOUNCE_CYC,
    parameter int N_PARAMS = ifp_pkg::N_MENU_PARAMS
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous reset, high
    input wire logic [ifp_pkg::N_BTN-1:0] btn_pins, // sel, dn, up, ex pins
    input wire logic [ifp_pkg::FRAC_W-1:0] meas_frac, // input as fraction of 4..20 mA
    input wire ifp_pkg::ifp_nvm_cfg_t nvm_cfg, // stored calibration and options
    input wire logic [1:0] alarm_en, // optional alarms enabled
    input wire logic signed [ifp_pkg::VAL_W-1:0] alarm_sp, // alarm setpoint to show
    input wire logic param_changed, // menu function altered a setting
    input wire logic nvm_wr_done, // storage finished writing
    output ifp_pkg::ifp_disp_out_t disp, // what the display shows
    output logic [$clog2(N_PARAMS)-1:0] menu_param, // selected menu parameter
    output logic [1:0] code_pos, // digit being keyed
    output logic in_menu, // programming menu open
    output logic nvm_wr_req // one-cycle store request
);
    localparam int PW = $clog2(N_PARAMS);
    localparam int VW = ifp_pkg::VAL_W;
    localparam int FW = ifp_pkg::FRAC_W;

    typedef struct packed {
        ifp_pkg::ifp_state_t st;
        ifp_pkg::ifp_btn_t prev;
        logic [ifp_pkg::CODE_W-1:0] entry;
        logic [1:0] pos;
        logic [PW-1:0] param;
        logic dirty;
        logic wr_seen;
        logic wr_req;
        logic [31:0] step_cnt;
        ifp_pkg::ifp_disp_out_t disp;
    } ifp_ctl_st_t;

    ifp_ctl_st_t q, n;

    if (START_DELAY_CYC < 1 || TEST_CYC < 1 || BLANK_CYC < 1 || DASH_CYC < 1 ||
        DASH_STEP_CYC < 1 || STORE_CYC < 1 || DEBOUNCE_CYC < 1 || N_PARAMS < 2) begin : g_chk
        $error("ifp_panel_ctrl: bad parameters");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buttons and sequence timer
    ifp_pkg::ifp_btn_t db;
    logic [ifp_pkg::N_BTN-1:0] db_raw;
    logic tmr_load;
    logic [31:0] tmr_val;
    logic tmr_exp;

    ifp_debounce #(.N(ifp_pkg::N_BTN), .CNT_MAX(DEBOUNCE_CYC)) u_deb (
        .core_clk(core_clk),
        .reset(reset),
        .raw(btn_pins),
        .stable(db_raw)
    );

    assign db = ifp_pkg::ifp_btn_t'(db_raw);

    ifp_timer #(.RST_CNT(START_DELAY_CYC)) u_tmr (
        .core_clk(core_clk),
        .reset(reset),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_exp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // scaling of the measurement
    logic signed [VW-1:0] eff_lo, eff_hi, eng_val, pct_val, ma_val;
    logic signed [VW:0] span;
    logic signed [VW+FW+1:0] prod;
    logic [VW+FW-1:0] pct_p, ma_p;

    assign eff_lo = nvm_cfg.valid ? nvm_cfg.lo : ifp_pkg::CAL_LO_DEF;
    assign eff_hi = nvm_cfg.valid ? nvm_cfg.hi : ifp_pkg::CAL_HI_DEF;
    assign span = {eff_hi[VW-1], eff_hi} - {eff_lo[VW-1], eff_lo};
    assign prod = span * $signed({1'b0, meas_frac});
    assign eng_val = eff_lo + prod[VW+FW-1:FW];
    assign pct_p = meas_frac * ifp_pkg::PCT_FULL_X100;
    assign ma_p = meas_frac * ifp_pkg::MA_SPAN_X100;
    assign pct_val = $signed(pct_p[VW+FW-1:FW]);
    assign ma_val = $signed(ifp_pkg::MA_LO_X100 + ma_p[VW+FW-1:FW]);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [3:0] bcd_step(input logic [3:0] dig, input logic inc);
        if (inc) begin
            return (dig >= ifp_pkg::BCD_MAX) ? 4'h0 : dig + 4'h1;
        end
        return (dig == 4'h0) ? ifp_pkg::BCD_MAX : dig - 4'h1;
    endfunction : bcd_step

    function automatic logic [PW-1:0] param_step(input logic [PW-1:0] p, input logic inc);
        if (inc) begin
            return (p == PW'(N_PARAMS - 1)) ? '0 : p + PW'(1);
        end
        return (p == '0) ? PW'(N_PARAMS - 1) : p - PW'(1);
    endfunction : param_step

    ////////////////////////////////////////////////////////////////////////////////
    // control
    ifp_pkg::ifp_btn_t press;
    logic combo;
    logic step_ph;

    always_comb begin
        n = q;
        n.wr_req = 1'b0;
        tmr_load = 1'b0;
        tmr_val = 32'h0000_0000;
        press = db & ~q.prev;
        n.prev = db;
        combo = db.sel & db.ex & ~(q.prev.sel & q.prev.ex);
        step_ph = 1'b0;
        if (nvm_wr_done) begin
            n.wr_seen = 1'b1;
        end
        unique case (q.st)
            ifp_pkg::ST_WAIT: begin
                if (tmr_exp) begin
                    n.st = ifp_pkg::ST_TEST;
                    tmr_load = 1'b1;
                    tmr_val = 32'(TEST_CYC);
                end
            end
            ifp_pkg::ST_TEST: begin
                if (tmr_exp) begin
                    n.st = ifp_pkg::ST_BLANK;
                    tmr_load = 1'b1;
                    tmr_val = 32'(BLANK_CYC);
                end
            end
            ifp_pkg::ST_BLANK: begin
                if (tmr_exp) begin
                    n.st = ifp_pkg::ST_DASH;
                    n.step_cnt = 32'(DASH_STEP_CYC - 1);
                    tmr_load = 1'b1;
                    tmr_val = 32'(DASH_CYC);
                end
            end
            ifp_pkg::ST_DASH: begin
                step_ph = 1'b1;
                if (tmr_exp) begin
                    n.st = ifp_pkg::ST_RUN;
                end
            end
            ifp_pkg::ST_RUN: begin
                if (combo) begin
                    if (nvm_cfg.code == ifp_pkg::CODE_DISABLED) begin
                        n.st = ifp_pkg::ST_MENU;
                        n.param = '0;
                        n.dirty = 1'b0;
                    end else begin
                        n.st = ifp_pkg::ST_PROMPT;
                    end
                end
            end
            ifp_pkg::ST_PROMPT: begin
                if (press.sel) begin
                    n.st = ifp_pkg::ST_CODE;
                    n.entry = '0;
                    n.pos = 2'b00;
                end else if (press.ex) begin
                    n.st = ifp_pkg::ST_RUN;
                end
            end
            ifp_pkg::ST_CODE: begin
                if (press.ex) begin
                    if (q.entry == nvm_cfg.code) begin
                        n.st = ifp_pkg::ST_MENU;
                        n.param = '0;
                        n.dirty = 1'b0;
                    end else begin
                        n.st = ifp_pkg::ST_RUN;
                    end
                end else if (press.up) begin
                    n.entry[q.pos*4 +: 4] = bcd_step(q.entry[q.pos*4 +: 4], 1'b1);
                end else if (press.dn) begin
                    n.entry[q.pos*4 +: 4] = bcd_step(q.entry[q.pos*4 +: 4], 1'b0);
                end else if (press.sel) begin
                    n.pos = q.pos + 2'b01;
                end
            end
            ifp_pkg::ST_MENU: begin
                if (press.ex) begin
                    if (q.dirty || param_changed) begin
                        n.st = ifp_pkg::ST_STORE;
                        n.wr_req = 1'b1;
                        n.wr_seen = 1'b0;
                        n.step_cnt = 32'(DASH_STEP_CYC - 1);
                        tmr_load = 1'b1;
                        tmr_val = 32'(STORE_CYC);
                    end else begin
                        n.st = ifp_pkg::ST_RUN;
                    end
                end else if (press.up) begin
                    n.param = param_step(q.param, 1'b1);
                end else if (press.dn) begin
                    n.param = param_step(q.param, 1'b0);
                end
            end
            ifp_pkg::ST_STORE: begin
                step_ph = 1'b1;
                if (tmr_exp && q.wr_seen) begin
                    n.st = ifp_pkg::ST_RUN;
                    n.dirty = 1'b0;
                end
            end
            default: begin
                n.st = ifp_pkg::ST_WAIT;
            end
        endcase
        // a change reported in the exit cycle is not lost
        if (param_changed && q.st == ifp_pkg::ST_MENU && n.st == ifp_pkg::ST_MENU) begin
            n.dirty = 1'b1;
        end
        if (step_ph) begin
            if (q.step_cnt == 32'h0000_0000) begin
                n.step_cnt = 32'(DASH_STEP_CYC - 1);
                n.disp.phase = q.disp.phase + 2'b01;
            end else begin
                n.step_cnt = q.step_cnt - 32'h0000_0001;
            end
        end
        // display follows the next state
        n.disp.value = '0;
        unique case (n.st)
            ifp_pkg::ST_WAIT: n.disp.kind = ifp_pkg::DK_BLANK;
            ifp_pkg::ST_TEST: n.disp.kind = ifp_pkg::DK_ALL_ON;
            ifp_pkg::ST_BLANK: n.disp.kind = ifp_pkg::DK_BLANK;
            ifp_pkg::ST_DASH: n.disp.kind = ifp_pkg::DK_DASH;
            ifp_pkg::ST_PROMPT: n.disp.kind = ifp_pkg::DK_CODE_PROMPT;
            ifp_pkg::ST_CODE: begin
                n.disp.kind = ifp_pkg::DK_CODE_ENTRY;
                n.disp.value = $signed({{(VW - ifp_pkg::CODE_W){1'b0}}, n.entry});
            end
            ifp_pkg::ST_MENU: begin
                n.disp.kind = ifp_pkg::DK_MENU;
                n.disp.value = $signed({{(VW - PW){1'b0}}, n.param});
            end
            ifp_pkg::ST_STORE: n.disp.kind = ifp_pkg::DK_STORING;
            ifp_pkg::ST_RUN: begin
                if (db.sel && alarm_en != 2'b00) begin
                    n.disp.kind = ifp_pkg::DK_SETPOINT;
                    n.disp.value = alarm_sp;
                end else if (db.sel) begin
                    n.disp.kind = nvm_cfg.sel_pct ? ifp_pkg::DK_PCT : ifp_pkg::DK_MA;
                    n.disp.value = nvm_cfg.sel_pct ? pct_val : ma_val;
                end else if (db.dn) begin
                    n.disp.kind = ifp_pkg::DK_CAL_LO;
                    n.disp.value = eff_lo;
                end else if (db.up) begin
                    n.disp.kind = ifp_pkg::DK_CAL_HI;
                    n.disp.value = eff_hi;
                end else begin
                    n.disp.kind = ifp_pkg::DK_ENG;
                    n.disp.value = eng_val;
                end
            end
            default: n.disp.kind = ifp_pkg::DK_BLANK;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
            q.st <= ifp_pkg::ST_WAIT;
            q.disp.kind <= ifp_pkg::DK_BLANK;
        end else begin
            q <= n;
        end
    end

    assign disp = q.disp;
    assign menu_param = q.param;
    assign code_pos = q.pos;
    assign in_menu = (q.st == ifp_pkg::ST_MENU);
    assign nvm_wr_req = q.wr_req;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    chk_test_to_blank: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_TEST && tmr_exp) |=> (q.st == ifp_pkg::ST_BLANK && disp.kind == ifp_pkg::DK_BLANK)
    ) else $error("blank does not follow segment test");
    chk_test_lit: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_WAIT && tmr_exp) |=> (disp.kind == ifp_pkg::DK_ALL_ON) [*2]
    ) else $error("segment test not shown");
    chk_dash_to_run: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_DASH && tmr_exp) |=> (q.st == ifp_pkg::ST_RUN)
    ) else $error("normal display does not follow dashes");
    chk_eng_view: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_RUN && !db.sel && !db.dn && !db.up && !combo)
        |=> (disp.kind == ifp_pkg::DK_ENG && disp.value == $past(eng_val))
    ) else $error("engineering value not shown");
    chk_down_view: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_RUN && db.dn && !db.sel && !combo)
        |=> (disp.kind == ifp_pkg::DK_CAL_LO && disp.value == $past(eff_lo))
    ) else $error("4 mA calibration not shown");
    chk_alarm_sel: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_RUN && db.sel && !db.ex && alarm_en != 2'b00)
        |=> (disp.kind == ifp_pkg::DK_SETPOINT)
    ) else $error("select view not altered by alarm");
    chk_exit_ignored: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_RUN && press.ex && !db.sel) |=> (q.st == ifp_pkg::ST_RUN)
    ) else $error("exit alone left display mode");
    chk_open_entry: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_RUN && combo && nvm_cfg.code == ifp_pkg::CODE_DISABLED)
        |=> (q.st == ifp_pkg::ST_MENU && menu_param == '0)
    ) else $error("menu not opened at first parameter");
    chk_code_prompt: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_RUN && combo && nvm_cfg.code != ifp_pkg::CODE_DISABLED)
        |=> (disp.kind == ifp_pkg::DK_CODE_PROMPT)
    ) else $error("code prompt not shown");
    chk_wrong_code: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_CODE && press.ex && q.entry != nvm_cfg.code) |=> (q.st == ifp_pkg::ST_RUN)
    ) else $error("wrong code granted access");
    chk_early_buttons: assert property (@(posedge core_clk) disable iff (reset)
        (q.st inside {ifp_pkg::ST_WAIT, ifp_pkg::ST_TEST, ifp_pkg::ST_BLANK})
        |=> !(q.st inside {ifp_pkg::ST_MENU, ifp_pkg::ST_PROMPT, ifp_pkg::ST_RUN})
    ) else $error("buttons acted during start-up");
    chk_store_req: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_MENU && press.ex && q.dirty)
        |=> (nvm_wr_req && disp.kind == ifp_pkg::DK_STORING) ##1 !nvm_wr_req
    ) else $error("store not requested after change");
    chk_menu_step: assert property (@(posedge core_clk) disable iff (reset)
        (q.st == ifp_pkg::ST_MENU && press.up && !press.ex && q.param != PW'(N_PARAMS - 1))
        |=> (menu_param == $past(menu_param) + PW'(1))
    ) else $error("menu did not step up");
    chk_default_cal: assert property (@(posedge core_clk) disable iff (reset)
        !nvm_cfg.valid |-> (eff_lo == ifp_pkg::CAL_LO_DEF && eff_hi == ifp_pkg::CAL_HI_DEF)
    ) else $error("default calibration wrong");

endmodule : ifp_panel_ctrl

//--- logic/ifp_pkg.sv
// shared constants and types of the indicator front-panel control
package ifp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and times
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int START_DELAY_MS = 100;
    localparam int TEST_MS = 500;
    localparam int BLANK_MS = 500;
    localparam int DASH_MS = 3000;
    localparam int DASH_STEP_MS = 250;
    localparam int STORE_MS = 2000;
    localparam int DEBOUNCE_MS = 20;
    localparam int START_DELAY_CYC = START_DELAY_MS * CYC_PER_MS;
    localparam int TEST_CYC = TEST_MS * CYC_PER_MS;
    localparam int BLANK_CYC = BLANK_MS * CYC_PER_MS;
    localparam int DASH_CYC = DASH_MS * CYC_PER_MS;
    localparam int DASH_STEP_CYC = DASH_STEP_MS * CYC_PER_MS;
    localparam int STORE_CYC = STORE_MS * CYC_PER_MS;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;

    ////////////////////////////////////////////////////////////////////////////////
    // widths and values
    localparam int VAL_W = 20;
    localparam int FRAC_W = 16;
    localparam int CODE_W = 16;
    localparam int N_BTN = 4;
    localparam int N_MENU_PARAMS = 12;
    localparam logic signed [VAL_W-1:0] CAL_LO_DEF = 20'sh00000;
    localparam logic signed [VAL_W-1:0] CAL_HI_DEF = 20'sh02710;
    localparam logic [VAL_W-1:0] MA_LO_X100 = 20'h00190;
    localparam logic [VAL_W-1:0] MA_SPAN_X100 = 20'h00640;
    localparam logic [VAL_W-1:0] PCT_FULL_X100 = 20'h02710;
    localparam logic [CODE_W-1:0] CODE_DISABLED = 16'h0000;
    localparam logic [3:0] BCD_MAX = 4'h9;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic sel;
        logic dn;
        logic up;
        logic ex;
    } ifp_btn_t;

    typedef enum logic [8:0] {
        ST_WAIT = 9'h001,
        ST_TEST = 9'h002,
        ST_BLANK = 9'h004,
        ST_DASH = 9'h008,
        ST_RUN = 9'h010,
        ST_PROMPT = 9'h020,
        ST_CODE = 9'h040,
        ST_MENU = 9'h080,
        ST_STORE = 9'h100
    } ifp_state_t;

    typedef enum logic [3:0] {
        DK_BLANK = 4'h0,
        DK_ALL_ON = 4'h1,
        DK_DASH = 4'h2,
        DK_ENG = 4'h3,
        DK_MA = 4'h4,
        DK_PCT = 4'h5,
        DK_CAL_LO = 4'h6,
        DK_CAL_HI = 4'h7,
        DK_SETPOINT = 4'h8,
        DK_CODE_PROMPT = 4'h9,
        DK_CODE_ENTRY = 4'ha,
        DK_MENU = 4'hb,
        DK_STORING = 4'hc
    } ifp_disp_t;

    typedef struct packed {
        ifp_disp_t kind;
        logic [1:0] phase;
        logic signed [VAL_W-1:0] value;
    } ifp_disp_out_t;

    typedef struct packed {
        logic valid;
        logic signed [VAL_W-1:0] lo;
        logic signed [VAL_W-1:0] hi;
        logic [CODE_W-1:0] code;
        logic sel_pct;
    } ifp_nvm_cfg_t;

endpackage : ifp_pkg

//--- logic/ifp_timer.sv
// loadable down-counter for display sequence intervals
`timescale 1ns/1ps
module ifp_timer #(
    parameter int RST_CNT = 1
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous reset, high
    input wire logic load, // start a new interval
    input wire logic [31:0] load_val, // interval length in cycles
    output logic expired // interval over
);
    typedef struct packed {
        logic [31:0] cnt;
    } ifp_tmr_st_t;

    ifp_tmr_st_t q, d;

    always_comb begin
        d = q;
        if (load) begin
            d.cnt = load_val;
        end else if (q.cnt != 32'h0000_0000) begin
            d.cnt = q.cnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q.cnt <= 32'(RST_CNT);
        end else begin
            q <= d;
        end
    end

    assign expired = (q.cnt == 32'h0000_0000);

endmodule : ifp_timer

//--- testbench/ifp_op_model.sv
// operator model: push-button pins
`timescale 1ns/1ps
module ifp_op_model (
    input wire logic core_clk, // clock
    input wire logic [3:0] press, // buttons wanted
    output logic [3:0] btn_pins // pins, high pressed
);
    always @(posedge core_clk) btn_pins <= press;
endmodule : ifp_op_model

//--- testbench/testbench.sv
// testbench of the front-panel control
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [3:0] b;
        logic [2:0] o;
        ifp_pkg::ifp_disp_t k;
        logic signed [19:0] v;
    } ifp_row_t;
    logic core_clk, reset, param_changed, nvm_wr_done, in_menu, nvm_wr_req;
    logic [3:0] press, btn_pins, menu_param;
    logic [1:0] alarm_en, code_pos;
    ifp_pkg::ifp_nvm_cfg_t nvm_cfg;
    ifp_pkg::ifp_disp_out_t disp;
    int errors, compares, reqs;
    logic [1:0] p;
    ifp_row_t rows[8];
    logic [15:0] meas_frac;
    logic signed [19:0] alarm_sp;
    localparam int T_DLY = 5, T_TEST = 20, T_BLANK = 20, T_DASH = 40, T_STEP = 4, T_STORE = 30, T_DEB = 3;
    ifp_panel_ctrl #(.START_DELAY_CYC(T_DLY), .TEST_CYC(T_TEST), .BLANK_CYC(T_BLANK), .DASH_CYC(T_DASH),
        .DASH_STEP_CYC(T_STEP), .STORE_CYC(T_STORE), .DEBOUNCE_CYC(T_DEB)) dut (.core_clk(core_clk),
        .reset(reset), .btn_pins(btn_pins), .meas_frac(meas_frac), .nvm_cfg(nvm_cfg), .alarm_en(alarm_en),
        .alarm_sp(alarm_sp), .param_changed(param_changed), .nvm_wr_done(nvm_wr_done), .disp(disp),
        .menu_param(menu_param), .code_pos(code_pos), .in_menu(in_menu), .nvm_wr_req(nvm_wr_req));
    ifp_op_model op (.core_clk(core_clk), .press(press), .btn_pins(btn_pins));
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (nvm_wr_req === 1'h1) reqs++;
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen %0h want %0h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic hold(input logic [3:0] m);
        press = m;
        cyc(12);
    endtask : hold
    task automatic tap(input logic [3:0] m);
        hold(m);
        hold(4'h0);
    endtask : tap
    task automatic wk(input ifp_pkg::ifp_disp_t k, input int lo, hi);
        int n;
        n = 0;
        while (disp.kind !== k && n <= hi) begin
            cyc(1);
            n++;
        end
        chk(n >= lo && n <= hi, 64'h1);
    endtask : wk
    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #50000;
        errors++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {errors, compares, reqs} = '0;
        {press, param_changed, nvm_wr_done, alarm_en, nvm_cfg} = '0;
        meas_frac = 16'h4000;
        alarm_sp = 20'sh00123;
        reset = 1'h1;
        rows = '{'{4'h0, 3'h0, ifp_pkg::DK_ENG, 20'sh009c4}, '{4'h1, 3'h0, ifp_pkg::DK_ENG, 20'sh009c4},
            '{4'h8, 3'h0, ifp_pkg::DK_MA, 20'sh00320}, '{4'h8, 3'h4, ifp_pkg::DK_PCT, 20'sh009c4},
            '{4'h4, 3'h0, ifp_pkg::DK_CAL_LO, 20'sh0}, '{4'h2, 3'h0, ifp_pkg::DK_CAL_HI, 20'sh02710},
            '{4'h8, 3'h2, ifp_pkg::DK_SETPOINT, 20'sh00123}, '{4'h0, 3'h1, ifp_pkg::DK_ENG, 20'sh0044c}};
        cyc(3);
        chk({disp, menu_param, code_pos, in_menu, nvm_wr_req}, 64'h0);
        reset = 1'h0;
        wk(ifp_pkg::DK_ALL_ON, 4, 9);
        wk(ifp_pkg::DK_BLANK, 19, 22);
        wk(ifp_pkg::DK_DASH, 19, 22);
        p = disp.phase;
        press = 4'h4;
        cyc(10);
        chk(disp.kind, ifp_pkg::DK_DASH);
        chk(disp.phase != p, 64'h1);
        press = 4'h0;
        wk(ifp_pkg::DK_ENG, 27, 33);
        foreach (rows[i]) begin
            {nvm_cfg.sel_pct, alarm_en[0], nvm_cfg.valid} = rows[i].o;
            nvm_cfg.lo = rows[i].o[0] ? 20'sh00064 : 20'sh0;
            nvm_cfg.hi = rows[i].o[0] ? 20'sh00834 : 20'sh0;
            meas_frac = rows[i].o[0] ? 16'h8000 : 16'h4000;
            hold(rows[i].b);
            chk(disp.kind, rows[i].k);
            chk(disp.value, rows[i].v);
            hold(4'h0);
        end
        nvm_cfg = '0;
        hold(4'h9);
        chk({in_menu, disp.kind, menu_param}, {1'h1, ifp_pkg::DK_MENU, 4'h0});
        tap(4'h0);
        tap(4'h2);
        chk(menu_param, 64'h1);
        tap(4'h4);
        tap(4'h4);
        chk(menu_param, 64'hb);
        param_changed = 1'h1;
        cyc(1);
        param_changed = 1'h0;
        hold(4'h1);
        chk({disp.kind, reqs}, {ifp_pkg::DK_STORING, 32'h1});
        nvm_wr_done = 1'h1;
        cyc(1);
        nvm_wr_done = 1'h0;
        hold(4'h0);
        wk(ifp_pkg::DK_ENG, 0, 32);
        nvm_cfg.code = 16'h0001;
        tap(4'h9);
        chk(disp.kind, ifp_pkg::DK_CODE_PROMPT);
        tap(4'h8);
        chk(disp.kind, ifp_pkg::DK_CODE_ENTRY);
        tap(4'h2);
        chk(disp.value, 64'h1);
        tap(4'h1);
        chk({in_menu, disp.kind}, {1'h1, ifp_pkg::DK_MENU});
        tap(4'h1);
        chk({disp.kind, reqs}, {ifp_pkg::DK_ENG, 32'h1});
        tap(4'h9);
        tap(4'h8);
        tap(4'h8);
        chk(code_pos, 64'h1);
        tap(4'h1);
        chk({in_menu, disp.kind}, {1'h0, ifp_pkg::DK_ENG});
        reset = 1'h1;
        cyc(3);
        chk({disp, menu_param, code_pos, in_menu, nvm_wr_req}, 64'h0);
        reset = 1'h0;
        wk(ifp_pkg::DK_ALL_ON, 4, 9);
        tally_and_finish();
    end
endmodule : testbench
